// ===== audio_pin_pkg.sv
// Shared constants and carriers for primary audio port pin routing
package audio_pin_pkg;
	localparam int          PIN_CNT        = 13;
	localparam int          GPIO_CNT       = 10;
	localparam int          SYNC_STAGES    = 2;
	// Register offsets
	localparam logic [7:0]  OFS_KEEPER     = 8'h05;
	localparam logic [7:0]  OFS_BCLK       = 8'h08;
	localparam logic [7:0]  OFS_WCLK       = 8'h09;
	localparam logic [7:0]  OFS_DATA       = 8'h0c;
	// Reset values
	localparam logic [7:0]  RST_KEEPER     = 8'h00;
	localparam logic [7:0]  RST_BCLK       = 8'h00;
	localparam logic [7:0]  RST_WCLK       = 8'h08;
	localparam logic [7:0]  RST_DATA       = 8'h00;
	// Writable field masks, reserved bits read zero
	localparam logic [7:0]  MASK_KEEPER    = 8'h80;
	localparam logic [7:0]  MASK_BCLK      = 8'h7b;
	localparam logic [7:0]  MASK_WCLK      = 8'h7a;
	localparam logic [7:0]  MASK_DATA      = 8'h7b;
	// Field positions
	localparam int          BIT_KEEPER_PD  = 7;
	localparam int          SEL_HI         = 6;
	localparam int          SEL_LO         = 3;
	localparam int          BIT_INVERT     = 1;
	localparam int          BIT_FREE_RUN   = 0;
	localparam int          SRC_HI         = 1;
	localparam int          SRC_LO         = 0;
	// Pin codes
	localparam logic [3:0]  CODE_GPIO_LAST = 4'h9;
	localparam logic [3:0]  CODE_GPI_FIRST = 4'hc;
	localparam logic [3:0]  CODE_GPI_LAST  = 4'he;

	typedef enum logic [1:0] {
		SRC_NORMAL_ISENSE = 2'h0,
		SRC_LOOP_PRIMARY  = 2'h1,
		SRC_LOOP_SECOND   = 2'h2,
		SRC_NORMAL_CONFIG = 2'h3
	} out_source_e;

	typedef struct packed {
		logic [2:0] gpi;
		logic [9:0] gpio;
	} pin_bus_s;

	typedef struct packed {
		logic data;
		logic oe;
		logic keeper_pd;
	} serial_out_s;
endpackage

// ===== pin_code_select.sv
// Maps a four-bit pin code onto one of the synchronised port pins
module pin_code_select (
	input  wire logic [3:0]                  code,  // Pin select code
	input  wire audio_pin_pkg::pin_bus_s     pins,  // Synchronised pins
	output logic                             level, // Selected level, 0 if reserved
	output logic                             valid  // Code names a real pin
);
	always_comb begin
		level = 1'b0;
		valid = 1'b0;
		if (code <= audio_pin_pkg::CODE_GPIO_LAST) begin
			valid = 1'b1;
			level = pins.gpio[code];
		end else if (code >= audio_pin_pkg::CODE_GPI_FIRST &&
				code <= audio_pin_pkg::CODE_GPI_LAST) begin
			valid = 1'b1;
			level = pins.gpi[2'(code - audio_pin_pkg::CODE_GPI_FIRST)];
		end
	end
endmodule

// ===== audio_port_pin_routing.sv
// Primary audio port pin routing, clock polarity and serial output control
// Operation
// - Keeper bit set powers down the output keeper while output is tri-stated.
// - Bit clock comes from pin coded in bits 6-3; 0-9 GPIO, 12-14 GPI.
// - Bit clock invert bit set inverts bit clock polarity.
// - Free-run clear: clocks driven only when port active and codec powered.
// - Word clock pin chosen by bits 6-3, same code map, reset selects GPIO2.
// - Word clock invert bit set inverts word clock polarity.
// - Serial input comes from pin coded in bits 6-3, same code map.
// - Source 0: normal output, buffer enabled only while current sense powered.
// - Source 1 loops primary input back; source 2 loops second port input.
// - Source 3: normal output, buffer enable from port configuration alone.
// - Tri-state option releases output during extra bit clocks after data.
module audio_port_pin_routing (
	input  wire logic                    clk,              // 100 MHz clock
	input  wire logic                    rst_b,            // Async reset, active low
	input  wire logic                    reg_wr,           // Register write strobe
	input  wire logic [7:0]              reg_addr,         // Register offset
	input  wire logic [7:0]              reg_wdata,        // Write data
	output logic      [7:0]              reg_rdata,        // Read data
	input  wire audio_pin_pkg::pin_bus_s pins_in,          // Raw GPIO and GPI pins
	input  wire logic                    second_port_in,   // Second port serial input pin
	input  wire logic                    port_active,      // Port running
	input  wire logic                    codec_powered,    // Codec powered up
	input  wire logic                    isense_powered,   // Current sense powered
	input  wire logic                    port_drive,       // Port config wants output driven
	input  wire logic                    normal_data,      // Normal serial output bit
	input  wire logic                    tristate_option,  // Extra-cycle tri-state enable
	input  wire logic                    extra_cycles,     // Frame past its data slots
	output logic                         bit_clock,        // Routed bit clock, polarity applied
	output logic                         word_clock,       // Routed word clock, polarity applied
	output logic                         serial_in,        // Routed serial input
	output logic                         bit_clock_edge,   // Active bit clock edge pulse
	output logic                         clocks_out_en,    // Clock output drivers enabled
	output audio_pin_pkg::serial_out_s   serial_out        // Output pin data, enable, keeper
);
	logic                                rst_sync_q;
	logic                                rst_b_q;
	logic [7:0]                          keeper_q;
	logic [7:0]                          keeper_d;
	logic [7:0]                          bclk_cfg_q;
	logic [7:0]                          bclk_cfg_d;
	logic [7:0]                          wclk_cfg_q;
	logic [7:0]                          wclk_cfg_d;
	logic [7:0]                          data_cfg_q;
	logic [7:0]                          data_cfg_d;
	logic [audio_pin_pkg::PIN_CNT:0]     meta_q;
	logic [audio_pin_pkg::PIN_CNT:0]     sync_q;
	audio_pin_pkg::pin_bus_s             pins_sync;
	logic                                second_sync;
	logic                                bclk_sel;
	logic                                wclk_sel;
	logic                                din_sel;
	logic                                bclk_ok;
	logic                                wclk_ok;
	logic                                din_ok;
	logic                                bit_clock_q;
	logic                                bit_clock_d;
	logic                                word_clock_q;
	logic                                word_clock_d;
	logic                                serial_in_q;
	logic                                serial_in_d;
	logic                                edge_q;
	logic                                edge_d;
	logic                                clk_en_q;
	logic                                clk_en_d;
	audio_pin_pkg::serial_out_s          out_q;
	audio_pin_pkg::serial_out_s          out_d;
	audio_pin_pkg::out_source_e          src;

	// Reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 1'b0;
			rst_b_q    <= 1'b0;
		end else begin
			rst_sync_q <= 1'b1;
			rst_b_q    <= rst_sync_q;
		end
	end

	// Pin synchronisers; the second port input rides the top bit
	genvar gi;
	generate
		for (gi = 0; gi <= audio_pin_pkg::PIN_CNT; gi++) begin : g_sync
			logic raw;
			if (gi < audio_pin_pkg::PIN_CNT) begin : g_pin
				assign raw = pins_in[gi];
			end else begin : g_second
				assign raw = second_port_in;
			end
			always_ff @(posedge clk or negedge rst_b_q) begin
				if (!rst_b_q) begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end else begin
					meta_q[gi] <= raw;
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign pins_sync   = sync_q[audio_pin_pkg::PIN_CNT-1:0];
	assign second_sync = sync_q[audio_pin_pkg::PIN_CNT];

	// Register file
	always_comb begin
		keeper_d   = keeper_q;
		bclk_cfg_d = bclk_cfg_q;
		wclk_cfg_d = wclk_cfg_q;
		data_cfg_d = data_cfg_q;
		if (reg_wr) begin
			unique case (reg_addr)
				audio_pin_pkg::OFS_KEEPER: keeper_d   = reg_wdata & audio_pin_pkg::MASK_KEEPER;
				audio_pin_pkg::OFS_BCLK:   bclk_cfg_d = reg_wdata & audio_pin_pkg::MASK_BCLK;
				audio_pin_pkg::OFS_WCLK:   wclk_cfg_d = reg_wdata & audio_pin_pkg::MASK_WCLK;
				audio_pin_pkg::OFS_DATA:   data_cfg_d = reg_wdata & audio_pin_pkg::MASK_DATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b_q) begin
		if (!rst_b_q) begin
			keeper_q   <= audio_pin_pkg::RST_KEEPER;
			bclk_cfg_q <= audio_pin_pkg::RST_BCLK;
			wclk_cfg_q <= audio_pin_pkg::RST_WCLK;
			data_cfg_q <= audio_pin_pkg::RST_DATA;
		end else begin
			keeper_q   <= keeper_d;
			bclk_cfg_q <= bclk_cfg_d;
			wclk_cfg_q <= wclk_cfg_d;
			data_cfg_q <= data_cfg_d;
		end
	end

	// Unmapped offsets read zero
	always_comb begin
		unique case (reg_addr)
			audio_pin_pkg::OFS_KEEPER: reg_rdata = keeper_q;
			audio_pin_pkg::OFS_BCLK:   reg_rdata = bclk_cfg_q;
			audio_pin_pkg::OFS_WCLK:   reg_rdata = wclk_cfg_q;
			audio_pin_pkg::OFS_DATA:   reg_rdata = data_cfg_q;
			default:                   reg_rdata = 8'h00;
		endcase
	end

	pin_code_select u_bclk_sel (
		.code  (bclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]),
		.pins  (pins_sync),
		.level (bclk_sel),
		.valid (bclk_ok)
	);

	pin_code_select u_wclk_sel (
		.code  (wclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]),
		.pins  (pins_sync),
		.level (wclk_sel),
		.valid (wclk_ok)
	);

	pin_code_select u_din_sel (
		.code  (data_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]),
		.pins  (pins_sync),
		.level (din_sel),
		.valid (din_ok)
	);

	assign src = audio_pin_pkg::out_source_e'(
		data_cfg_q[audio_pin_pkg::SRC_HI:audio_pin_pkg::SRC_LO]);

	// Routing and output control
	always_comb begin
		// Invert only a real pin; an unconnected input stays low
		bit_clock_d  = bclk_ok & (bclk_sel ^ bclk_cfg_q[audio_pin_pkg::BIT_INVERT]);
		word_clock_d = wclk_ok & (wclk_sel ^ wclk_cfg_q[audio_pin_pkg::BIT_INVERT]);
		serial_in_d  = din_ok & din_sel;
		edge_d       = bit_clock_d & ~bit_clock_q;
		clk_en_d     = bclk_cfg_q[audio_pin_pkg::BIT_FREE_RUN] |
			(port_active & codec_powered);
		out_d        = '0;
		unique case (src)
			audio_pin_pkg::SRC_NORMAL_ISENSE: begin
				out_d.data = normal_data;
				out_d.oe   = port_drive & isense_powered;
			end
			audio_pin_pkg::SRC_LOOP_PRIMARY: begin
				out_d.data = serial_in_d;
				out_d.oe   = port_drive;
			end
			audio_pin_pkg::SRC_LOOP_SECOND: begin
				out_d.data = second_sync;
				out_d.oe   = port_drive;
			end
			audio_pin_pkg::SRC_NORMAL_CONFIG: begin
				out_d.data = normal_data;
				out_d.oe   = port_drive;
			end
		endcase
		if (tristate_option && extra_cycles) begin
			out_d.oe = 1'b0;
		end
		out_d.keeper_pd = keeper_q[audio_pin_pkg::BIT_KEEPER_PD] & ~out_d.oe;
	end

	always_ff @(posedge clk or negedge rst_b_q) begin
		if (!rst_b_q) begin
			bit_clock_q  <= 1'b0;
			word_clock_q <= 1'b0;
			serial_in_q  <= 1'b0;
			edge_q       <= 1'b0;
			clk_en_q     <= 1'b0;
			out_q        <= '0;
		end else begin
			bit_clock_q  <= bit_clock_d;
			word_clock_q <= word_clock_d;
			serial_in_q  <= serial_in_d;
			edge_q       <= edge_d;
			clk_en_q     <= clk_en_d;
			out_q        <= out_d;
		end
	end

	assign bit_clock      = bit_clock_q;
	assign word_clock     = word_clock_q;
	assign serial_in      = serial_in_q;
	assign bit_clock_edge = edge_q;
	assign clocks_out_en  = clk_en_q;
	assign serial_out     = out_q;

	a_keeper_follows: assert property (@(posedge clk) disable iff (!rst_b_q)
		out_q.keeper_pd == ($past(keeper_q[audio_pin_pkg::BIT_KEEPER_PD]) && !out_q.oe))
		else $error("keeper power-down does not track tri-state");

	a_bclk_gpio1: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(bclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]) == 4'h0
		&& !$past(bclk_cfg_q[audio_pin_pkg::BIT_INVERT])
		|-> bit_clock_q == $past(sync_q[0]))
		else $error("bit clock not taken from first GPIO");

	a_bclk_invert: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(bclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]) == 4'hc
		&& $past(bclk_cfg_q[audio_pin_pkg::BIT_INVERT])
		|-> bit_clock_q == !$past(sync_q[audio_pin_pkg::GPIO_CNT]))
		else $error("inverted bit clock from first GPI wrong");

	a_clock_gate: assert property (@(posedge clk) disable iff (!rst_b_q)
		!bclk_cfg_q[audio_pin_pkg::BIT_FREE_RUN] && !port_active ##1
		!$past(bclk_cfg_q[audio_pin_pkg::BIT_FREE_RUN]) |-> !clocks_out_en)
		else $error("clocks enabled while port idle");

	a_wclk_gpio2: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(wclk_cfg_q) == audio_pin_pkg::RST_WCLK |-> word_clock_q == $past(sync_q[1]))
		else $error("word clock not taken from second GPIO");

	a_wclk_invert: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(wclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]) == 4'h1
		&& $past(wclk_cfg_q[audio_pin_pkg::BIT_INVERT])
		|-> word_clock_q == !$past(sync_q[1]))
		else $error("inverted word clock wrong");

	a_din_route: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(data_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]) == 4'he
		|-> serial_in_q == $past(sync_q[audio_pin_pkg::PIN_CNT-1]))
		else $error("serial input not from third GPI");

	a_isense_gate: assert property (@(posedge clk) disable iff (!rst_b_q)
		src == audio_pin_pkg::SRC_NORMAL_ISENSE && !isense_powered |=> !out_q.oe)
		else $error("output driven without current sense power");

	a_loop_second: assert property (@(posedge clk) disable iff (!rst_b_q)
		src == audio_pin_pkg::SRC_LOOP_SECOND |=> out_q.data == $past(sync_q[audio_pin_pkg::PIN_CNT]))
		else $error("second port loopback data wrong");

	a_config_drive: assert property (@(posedge clk) disable iff (!rst_b_q)
		src == audio_pin_pkg::SRC_NORMAL_CONFIG && port_drive
		&& !(tristate_option && extra_cycles) |=> out_q.oe)
		else $error("configured output not driven");

	a_extra_release: assert property (@(posedge clk) disable iff (!rst_b_q)
		tristate_option && extra_cycles |=> !out_q.oe)
		else $error("output driven during extra bit clocks");

	a_reserved_low: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(bclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]) inside {4'ha, 4'hb, 4'hf}
		|-> !bit_clock_q && !edge_q)
		else $error("reserved bit clock code not held low");

	a_wclk_reserved: assert property (@(posedge clk) disable iff (!rst_b_q)
		$past(wclk_cfg_q[audio_pin_pkg::SEL_HI:audio_pin_pkg::SEL_LO]) inside {4'ha, 4'hb, 4'hf}
		|-> !word_clock_q)
		else $error("reserved word clock code not held low");

	a_loop_primary: assert property (@(posedge clk) disable iff (!rst_b_q)
		src == audio_pin_pkg::SRC_LOOP_PRIMARY |=> out_q.data == serial_in_q)
		else $error("primary loopback data wrong");

	a_edge_pulse: assert property (@(posedge clk) disable iff (!rst_b_q)
		edge_q |-> bit_clock_q && !$past(bit_clock_q))
		else $error("bit clock edge pulse without a rising edge");
endmodule

// ===== host_audio_model.sv
// Host audio processor model driving bit clock, word clock and serial data
module host_audio_model (
	input  wire logic run,   // Frames in progress
	output logic      bclk,  // Bit clock, stands low between frames
	output logic      wclk,  // Word clock, toggles every 8 bit clocks
	output logic      sdata  // Serial data, pulled low between frames
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	initial begin
		bclk = 1'b0;
		wclk = 1'b0;
		sdata = 1'b0;
		n = 0;
		#3;
		// Odd start offset keeps the phase unrelated to the block's clock
		forever begin
			wait (run);
			#62.5 bclk = 1'b1;
			n++;
			if (n % 8 == 0) begin
				wclk = ~wclk;
			end
			#62.5 bclk = 1'b0;
			sdata = run ? ~sdata : 1'b0;
		end
	end
endmodule

// ===== audio_port_pin_routing_tb_top.sv
// Testbench for primary audio port pin routing
module audio_port_pin_routing_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       clk, rst_b, reg_wr, second_port_in, port_active;
	logic                       codec_powered, isense_powered, port_drive, normal_data;
	logic                       tristate_option, extra_cycles, run, counting;
	logic                       bit_clock, word_clock, serial_in, bit_clock_edge;
	logic                       clocks_out_en, m_bc, m_wc, m_sd;
	logic [7:0]                 reg_addr, reg_wdata, reg_rdata, n_rise, n_edge;
	logic [12:0]                spare_q;
	audio_pin_pkg::pin_bus_s    pins_in;
	audio_pin_pkg::serial_out_s serial_out;
	int                         fail_count, n_compared, cyc;

	assign pins_in = spare_q ^ {2'h0, m_sd, 8'h0, m_wc, m_bc};

	audio_port_pin_routing u_audio_port_pin_routing (
		.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pins_in(pins_in),
		.second_port_in(second_port_in), .port_active(port_active),
		.codec_powered(codec_powered), .isense_powered(isense_powered),
		.port_drive(port_drive), .normal_data(normal_data),
		.tristate_option(tristate_option), .extra_cycles(extra_cycles),
		.bit_clock(bit_clock), .word_clock(word_clock), .serial_in(serial_in),
		.bit_clock_edge(bit_clock_edge), .clocks_out_en(clocks_out_en),
		.serial_out(serial_out)
	);

	host_audio_model u_host_audio_model (.run(run), .bclk(m_bc), .wclk(m_wc), .sdata(m_sd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge m_bc) if (counting) n_rise++;
	always @(posedge clk) begin
		if (counting && bit_clock_edge) n_edge++;
		cyc++;
		if (cyc == 10000) begin
			fail_count++;
			$display("Error at %0t: run did not finish", $time);
			complete_run();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask

	// Covers the two sync flops and the output register with margin
	task automatic settle();
		repeat (5) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic sel_out(input int r);
		return (r == 0) ? bit_clock : (r == 1) ? word_clock : serial_in;
	endfunction

	task automatic test_regs();
		rd(8'h05, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h08);
		rd(8'h0c, 8'h00);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h00);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h80);
		wr(8'h08, 8'hff);
		rd(8'h08, 8'h7b);
		wr(8'h09, 8'hff);
		rd(8'h09, 8'h7a);
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'h7b);
		wr(8'h05, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h08);
		$display("test_regs done");
	endtask

	task automatic test_pins();
		logic [12:0] hot;
		logic [7:0]  ofs;
		for (int r = 0; r < 3; r++) begin
			ofs = (r == 0) ? 8'h08 : (r == 1) ? 8'h09 : 8'h0c;
			for (int c = 0; c < 16; c++) begin
				hot = (c < 10) ? 13'h1 << c : (c > 11 && c < 15) ? 13'h1 << (c - 2) : 13'h0;
				wr(ofs, {1'b0, 4'(c), 3'h0});
				spare_q <= hot;
				settle();
				chk({7'h0, sel_out(r)}, {7'h0, hot != 13'h0});
				spare_q <= ~hot;
				settle();
				chk({7'h0, sel_out(r)}, 8'h00);
			end
		end
		$display("test_pins done");
	endtask

	task automatic test_invert();
		wr(8'h08, 8'h02);
		wr(8'h09, 8'h0a);
		spare_q <= 13'h0;
		settle();
		chk({6'h0, bit_clock, word_clock}, 8'h03);
		spare_q <= 13'h3;
		settle();
		chk({6'h0, bit_clock, word_clock}, 8'h00);
		wr(8'h08, 8'h62);
		spare_q <= 13'h400;
		settle();
		chk({7'h0, bit_clock}, 8'h00);
		wr(8'h08, 8'h52);
		spare_q <= 13'h0;
		settle();
		chk({7'h0, bit_clock}, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h08);
		$display("test_invert done");
	endtask

	task automatic test_free_run();
		for (int i = 0; i < 8; i++) begin
			wr(8'h08, {7'h0, i[2]});
			port_active <= i[1];
			codec_powered <= i[0];
			settle();
			chk({7'h0, clocks_out_en}, {7'h0, i[2] | (i[1] & i[0])});
		end
		wr(8'h08, 8'h00);
		$display("test_free_run done");
	endtask

	task automatic test_output();
		logic d, oe, kb;
		for (int i = 0; i < 64; i++) begin
			kb = i[2] ^ i[5];
			wr(8'h05, {kb, 7'h0});
			wr(8'h0c, {5'h0c, 1'b0, i[1:0]});
			isense_powered <= i[2];
			port_drive <= i[3];
			tristate_option <= i[4];
			extra_cycles <= i[5];
			normal_data <= i[3] ^ i[0];
			spare_q <= {2'h0, i[2] ^ i[4], 10'h0};
			second_port_in <= ~(i[3] ^ i[5]);
			settle();
			oe = i[3] & (i[1:0] != 2'h0 || i[2]) & ~(i[4] & i[5]);
			d = (i[1:0] == 2'h1) ? i[2] ^ i[4] : (i[1:0] == 2'h2) ? ~(i[3] ^ i[5]) : i[3] ^ i[0];
			chk({5'h0, serial_out.data & serial_out.oe, serial_out.oe, serial_out.keeper_pd},
				{5'h0, d & oe, oe, kb & ~oe});
		end
		$display("test_output done");
	endtask

	task automatic test_link();
		wr(8'h0c, 8'h60);
		spare_q <= 13'h0;
		n_rise = 8'h0;
		n_edge = 8'h0;
		counting = 1'b1;
		run <= 1'b1;
		repeat (220) @(posedge clk);
		run <= 1'b0;
		repeat (30) @(posedge clk);
		counting = 1'b0;
		chk(n_edge, n_rise);
		chk({7'h0, n_rise != 8'h0}, 8'h01);
		$display("test_link done");
	endtask

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		{rst_b, reg_wr, second_port_in, port_active, codec_powered, isense_powered} = 6'h0;
		{port_drive, normal_data, tristate_option, extra_cycles, run, counting} = 6'h0;
		reg_addr = 8'h0;
		reg_wdata = 8'h0;
		spare_q = 13'h0;
		fail_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		test_regs();
		test_pins();
		test_invert();
		test_free_run();
		test_output();
		test_link();
		complete_run();
	end
endmodule
